// *** rtl/rtbm_pkg.sv ***
// constants for the terminal backend buffer mapper and memory sequencer
// assumes a single 100 MHz core clock and an attached 2K x 16 backend memory
package rtbm_pkg;
   // ======================================================
   // timing
   localparam int ClkMhz        = 100;
   localparam int AccLimitNs    = 1000;
   localparam int AccLimitCyc   = AccLimitNs * ClkMhz / 1000;
   localparam int AccOverheadCyc = 5;

   // ======================================================
   // memory layout
   localparam int MemAddrW  = 11;
   localparam int MemDataW  = 16;
   localparam logic [5:0] RxStatusPrefix = 6'h00;
   localparam logic [5:0] TxStatusPrefix = 6'h1F;
   localparam logic [4:0] LoopSubaddr    = 5'h1E;
   localparam logic [4:0] BcastAddr      = 5'h1F;

   // access type codes
   typedef enum logic [1:0] {
      RTBM_ACC_DATA = 2'h0,
      RTBM_ACC_TSW  = 2'h1,
      RTBM_ACC_CMD  = 2'h2,
      RTBM_ACC_NONE = 2'h3
   } rtbm_acc_t;

   // ======================================================
   // register map (byte addresses)
   localparam logic [3:0] RegCfgOfs    = 4'h0;
   localparam logic [3:0] RegStatusOfs = 4'h4;
   localparam logic [3:0] RegVectorOfs = 4'h8;
   // config field positions
   localparam int CfgCmdStore  = 0;
   localparam int CfgTswStore  = 1;
   localparam int CfgModeExt   = 2;
   localparam int CfgIrqBad    = 3;
   localparam int CfgAsync     = 4;
   localparam int CfgOverrun   = 5;
   localparam int CfgBcastEn   = 6;
   localparam int CfgLoop      = 7;
   localparam int CfgRtAddrLo  = 8;
   localparam logic [15:0] CfgReset    = 16'h0003;
   localparam logic [15:0] VectorReset = 16'h0000;

   // sequencer states, one-hot
   typedef enum logic [5:0] {
      RTBM_IDLE   = 6'h01,
      RTBM_REQ    = 6'h02,
      RTBM_SETUP  = 6'h04,
      RTBM_STROBE = 6'h08,
      RTBM_HOLD   = 6'h10,
      RTBM_DONE   = 6'h20
   } rtbm_state_t;
endpackage

// *** rtl/rtbm_backend.sv ***
// backend buffer mapper and memory access sequencer of a remote terminal
// assumes protocol logic issues one access at a time and a synchronous grant/wait
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - each memory access ends within 1 us of request; five cycles are overhead
// - memory is 2048 words of 16 bits, 64 buffers of 32 words
// - sub-addresses 1..30 have receive buffers low and transmit buffers high
// - transfer status words go to 000-01F receive, 3E0-3FF transmit
// - writes only to lower half; reads only upper half unless looped
// - command word written to status location at message start when enabled
// - transfer status word written only when its store enable is set
// - external mode data uses memory except last-command and self-test words
// - interrupts on bad messages only when that option is set
// - interface-select high gives asynchronous strobes, low synchronous
// - overrun test bit must stay low; it forces over-long transmit
// - broadcast enable makes address 31 broadcast, else ordinary address
// - loopback forces sub-address 30 transmit data into receive buffer
// - sub-address 30 transmit status word keeps its normal location
// - illegal state entry gives a single-cycle pulse
// - access type code 00 data, 01 status word, 10 command word
// - status and command addresses prefix sub-address with 000000 or 011111
module rtbm_backend
   import rtbm_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   // register bus
   input  wire logic [3:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output logic [31:0]              avs_readdata,
   output logic                     avs_waitrequest,
   // access requests from protocol logic
   input  wire logic                accValid,
   input  wire logic [1:0]          accKind,
   input  wire logic                accTx,
   input  wire logic [4:0]          accSubaddr,
   input  wire logic [4:0]          accWordIdx,
   input  wire logic                accModeData,
   input  wire logic                accModeInternal,
   input  wire logic [15:0]         accWrData,
   output logic                     accReady,
   output logic                     accDone,
   output logic [15:0]              accRdData,
   output logic                     memIfErr,
   // command and message events
   input  wire logic                cmdStrobe,
   input  wire logic [4:0]          cmdRtAddr,
   output logic                     cmdForUs,
   output logic                     cmdBroadcast,
   input  wire logic                msgEnd,
   input  wire logic                msgError,
   output logic                     msgIrq,
   output logic                     test_overrun_tx,
   output logic                     illegal_state_pulse,
   // backend memory
   output logic                     mem_request_n,
   input  wire logic                memGrant_n,
   output logic                     memWr_n,
   output logic                     memRd_n,
   output logic                     memCs_n,
   input  wire logic                memWait_n,
   output logic [1:0]               access_type_code,
   output logic [MemAddrW-1:0]      memAddr,
   output logic [MemDataW-1:0]      memDout,
   input  wire logic [MemDataW-1:0] memDin,
   output logic                     memCen,
   output logic                     memDen,
   output logic                     buffer_half_sel
);

   // ======================================================
   // helpers
   function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
      mergeBytes = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic [MemAddrW-1:0] mapAddr(input logic [1:0] kind,
                                                   input logic       tx,
                                                   input logic [4:0] sa,
                                                   input logic [4:0] idx,
                                                   input logic       loop);
      if (kind == RTBM_ACC_DATA)
         mapAddr = {tx & ~(loop && sa == LoopSubaddr), sa, idx};
      else
         mapAddr = {tx ? TxStatusPrefix : RxStatusPrefix, sa};
   endfunction

   logic [MemAddrW-1:0] mappedAddr;
   assign mappedAddr = mapAddr(accKind, accTx, accSubaddr, accWordIdx, loopEn);

   localparam int AccTimerW = $clog2(AccLimitCyc + 1);
   localparam int AccLimitI = AccLimitCyc;

   // ======================================================
   // register file
   logic [15:0]    cfg_reg;
   logic [15:0]    vector_reg;
   logic [7:0]     illegalCnt_reg;
   logic [7:0]     memErrCnt_reg;
   rtbm_state_t    state_reg;
   logic           busReq;

   assign busReq = avs_read | avs_write;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest <= ~(busReq & avs_waitrequest);
         if (avs_read && avs_waitrequest)
         begin
            case (avs_address)
               RegCfgOfs:    avs_readdata <= {16'h0000, cfg_reg};
               RegStatusOfs: avs_readdata <= {8'h00, illegalCnt_reg, memErrCnt_reg,
                                              2'h0, state_reg};
               RegVectorOfs: avs_readdata <= {16'h0000, vector_reg};
               default:      avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // configuration is meant to stay fixed once set
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_reg    <= CfgReset;
         vector_reg <= VectorReset;
      end
      else if (avs_write && !avs_waitrequest)
      begin
         if (avs_address == RegCfgOfs)
            cfg_reg <= mergeBytes(cfg_reg, avs_writedata, avs_byteenable) & 16'h1FFF;
         if (avs_address == RegVectorOfs)
            vector_reg <= mergeBytes(vector_reg, avs_writedata, avs_byteenable);
      end
   end

   logic       cmdStoreEn, tswStoreEn, modeExtEn, irqBadEn, asyncEn, broadcast_handling_en, loopEn;
   logic [4:0] termAddr;
   assign cmdStoreEn = cfg_reg[CfgCmdStore];
   assign tswStoreEn = cfg_reg[CfgTswStore];
   assign modeExtEn  = cfg_reg[CfgModeExt];
   assign irqBadEn   = cfg_reg[CfgIrqBad];
   assign asyncEn    = cfg_reg[CfgAsync];
   assign broadcast_handling_en    = cfg_reg[CfgBcastEn];
   assign loopEn     = cfg_reg[CfgLoop];
   assign termAddr   = cfg_reg[CfgRtAddrLo +: 5];

   // ======================================================
   // command decode and message interrupt
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cmdForUs        <= 1'b0;
         cmdBroadcast    <= 1'b0;
         msgIrq          <= 1'b0;
         test_overrun_tx <= 1'b0;
      end
      else
      begin
         cmdBroadcast    <= cmdStrobe && broadcast_handling_en && cmdRtAddr == BcastAddr;
         cmdForUs        <= cmdStrobe && ((broadcast_handling_en && cmdRtAddr == BcastAddr)
                                          || cmdRtAddr == termAddr);
         msgIrq          <= msgEnd && (!msgError || irqBadEn);
         test_overrun_tx <= cfg_reg[CfgOverrun];
      end
   end

   // ======================================================
   // memory access sequencer
   logic                  accWrite_reg;
   logic [AccTimerW-1:0]  timer_reg;
   logic                  suppress;
   logic                  accIsWrite;

   // mode data kept off memory returns the vector word instead
   always_comb
   begin
      suppress = 1'b0;
      if (accKind == RTBM_ACC_TSW && !tswStoreEn)
         suppress = 1'b1;
      if (accKind == RTBM_ACC_CMD && !cmdStoreEn)
         suppress = 1'b1;
      if (accKind == RTBM_ACC_NONE)
         suppress = 1'b1;
      if (accModeData && (!modeExtEn || accModeInternal))
         suppress = 1'b1;
   end
   assign accIsWrite = !(accKind == RTBM_ACC_DATA && accTx);

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg           <= RTBM_IDLE;
         accWrite_reg        <= 1'b0;
         timer_reg           <= '0;
         accReady            <= 1'b1;
         accDone             <= 1'b0;
         accRdData           <= 16'h0000;
         memIfErr            <= 1'b0;
         illegal_state_pulse <= 1'b0;
         mem_request_n       <= 1'b1;
         memWr_n             <= 1'b1;
         memRd_n             <= 1'b1;
         memCs_n             <= 1'b1;
         memCen              <= 1'b0;
         memDen              <= 1'b0;
         access_type_code    <= RTBM_ACC_DATA;
         memAddr             <= '0;
         memDout             <= 16'h0000;
         buffer_half_sel     <= 1'b0;
      end
      else
      begin
         accDone             <= 1'b0;
         memIfErr            <= 1'b0;
         illegal_state_pulse <= 1'b0;
         timer_reg           <= (state_reg == RTBM_IDLE) ? '0 : timer_reg + 1'b1;
         if ((state_reg == RTBM_REQ || state_reg == RTBM_SETUP || state_reg == RTBM_STROBE)
             && timer_reg >= AccTimerW'(AccLimitCyc - 2))
         begin
            // give up before the access window closes
            mem_request_n <= 1'b1;
            memWr_n       <= 1'b1;
            memRd_n       <= 1'b1;
            memCs_n       <= 1'b1;
            memCen        <= 1'b0;
            memDen        <= 1'b0;
            memIfErr      <= 1'b1;
            state_reg     <= RTBM_DONE;
         end
         else
         begin
            case (state_reg)
               RTBM_IDLE:
               begin
                  if (accValid)
                  begin
                     accReady         <= 1'b0;
                     accWrite_reg     <= accIsWrite;
                     access_type_code <= accKind;
                     memAddr          <= mappedAddr;
                     buffer_half_sel  <= mappedAddr[10];
                     memDout          <= accWrData;
                     accRdData        <= vector_reg;
                     if (suppress)
                        state_reg <= RTBM_DONE;
                     else
                     begin
                        mem_request_n <= 1'b0;
                        state_reg     <= RTBM_REQ;
                     end
                  end
               end
               RTBM_REQ:
               begin
                  if (!memGrant_n)
                  begin
                     memCs_n   <= 1'b0;
                     memCen    <= 1'b1;
                     memDen    <= accWrite_reg;
                     state_reg <= RTBM_SETUP;
                  end
               end
               RTBM_SETUP:
               begin
                  memWr_n   <= !accWrite_reg;
                  memRd_n   <= accWrite_reg;
                  state_reg <= RTBM_STROBE;
               end
               RTBM_STROBE:
               begin
                  if (!asyncEn || memWait_n)
                  begin
                     memWr_n <= 1'b1;
                     memRd_n <= 1'b1;
                     if (asyncEn && !accWrite_reg)
                        accRdData <= memDin;
                     state_reg <= RTBM_HOLD;
                  end
               end
               RTBM_HOLD:
               begin
                  if (!asyncEn && !accWrite_reg)
                     accRdData <= memDin;
                  mem_request_n <= 1'b1;
                  memCs_n       <= 1'b1;
                  memCen        <= 1'b0;
                  memDen        <= 1'b0;
                  state_reg     <= RTBM_DONE;
               end
               RTBM_DONE:
               begin
                  accDone   <= 1'b1;
                  accReady  <= 1'b1;
                  state_reg <= RTBM_IDLE;
               end
               default:
               begin
                  illegal_state_pulse <= 1'b1;
                  mem_request_n       <= 1'b1;
                  memWr_n             <= 1'b1;
                  memRd_n             <= 1'b1;
                  memCs_n             <= 1'b1;
                  memCen              <= 1'b0;
                  memDen              <= 1'b0;
                  accReady            <= 1'b1;
                  state_reg           <= RTBM_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         illegalCnt_reg <= 8'h00;
         memErrCnt_reg  <= 8'h00;
      end
      else
      begin
         if (illegal_state_pulse && illegalCnt_reg != 8'hFF)
            illegalCnt_reg <= illegalCnt_reg + 8'h01;
         if (memIfErr && memErrCnt_reg != 8'hFF)
            memErrCnt_reg <= memErrCnt_reg + 8'h01;
      end
   end

   // ======================================================
   // checks
   illegal_one_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
      illegal_state_pulse |=> !illegal_state_pulse)
      else $error("illegal state pulse longer than one cycle");
   req_within_limit_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(mem_request_n) |-> ##[1:AccLimitI] mem_request_n)
      else $error("memory request held past access limit");
   write_lower_half_a: assert property (@(posedge core_clk) disable iff (rst)
      !memWr_n |-> !memAddr[10] && !memCs_n)
      else $error("write outside lower half");
   read_upper_half_a: assert property (@(posedge core_clk) disable iff (rst)
      !memRd_n && !loopEn |-> memAddr[10] && access_type_code == RTBM_ACC_DATA)
      else $error("read outside transmit half");
   status_addr_a: assert property (@(posedge core_clk) disable iff (rst)
      !memCs_n && access_type_code != RTBM_ACC_DATA
      |-> memAddr[10:5] == RxStatusPrefix || memAddr[10:5] == TxStatusPrefix)
      else $error("status or command word at wrong address");
   tsw_suppress_a: assert property (@(posedge core_clk) disable iff (rst)
      state_reg == RTBM_IDLE && accValid && accKind == RTBM_ACC_TSW && !tswStoreEn
      |=> state_reg == RTBM_DONE ##1 accDone && mem_request_n)
      else $error("suppressed status word reached memory");
   cmd_suppress_a: assert property (@(posedge core_clk) disable iff (rst)
      state_reg == RTBM_IDLE && accValid && accKind == RTBM_ACC_CMD && !cmdStoreEn
      |=> mem_request_n [*2])
      else $error("suppressed command word reached memory");
   irq_filter_a: assert property (@(posedge core_clk) disable iff (rst)
      msgEnd |=> msgIrq == (!$past(msgError) || irqBadEn))
      else $error("message interrupt qualification wrong");
   bcast_decode_a: assert property (@(posedge core_clk) disable iff (rst)
      cmdStrobe && cmdRtAddr == BcastAddr |=> cmdBroadcast == broadcast_handling_en)
      else $error("broadcast decode wrong");
   sync_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(memRd_n) && !asyncEn |=> memRd_n)
      else $error("synchronous strobe longer than one cycle");
   loop_map_a: assert property (@(posedge core_clk) disable iff (rst)
      state_reg == RTBM_IDLE && accValid && loopEn && accTx && accSubaddr == LoopSubaddr
      |=> memAddr[10] == (accKind != RTBM_ACC_DATA ? 1'b0 : 1'b0)
          && memAddr[9:5] == (access_type_code == RTBM_ACC_DATA ? LoopSubaddr
                                                                 : 5'h1F))
      else $error("loopback mapping wrong");

endmodule
`default_nettype wire

// *** sim/rtbm_mem_model.sv ***
// backend memory model: two 1K x 16 halves with grant and wait handshakes
// assumes the backend is idle in reset and the bench preloads words it reads
`timescale 1ns/1ps
`default_nettype none
module rtbm_mem_model
   import rtbm_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                mem_request_n,
   input  wire logic                memWr_n,
   input  wire logic                memRd_n,
   input  wire logic                memCs_n,
   input  wire logic [MemAddrW-1:0] memAddr,
   input  wire logic [MemDataW-1:0] memDout,
   input  wire logic                buffer_half_sel,
   input  wire logic [1:0]          access_type_code,
   input  wire logic [7:0]          grantDly,
   input  wire logic [3:0]          waitCyc,
   output logic                     memGrant_n,
   output logic                     memWait_n,
   output logic [MemDataW-1:0]      memDin
);
   // ==========================================
   // storage and handshakes
   logic [MemDataW-1:0] mem [0:2047];
   logic [MemDataW-1:0] junk;
   logic [7:0]          gCnt;
   logic [3:0]          wCnt;
   logic [1:0]          lastType;
   logic                csPrev;
   int                  strobes;
   int                  upperWr;
   wire logic           strobe = !memWr_n || !memRd_n;
   assign memGrant_n = mem_request_n || (gCnt < grantDly);
   assign memWait_n = !(strobe && (wCnt < waitCyc));
   // released data lines hold for one more cycle, then toggle so stale values do not look valid
   assign memDin = (!memCs_n || csPrev) ? mem[{buffer_half_sel, memAddr[9:0]}] : junk;
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         gCnt <= 8'h00;
         wCnt <= 4'h0;
         csPrev <= 1'b0;
         junk <= 16'h5A5A;
         strobes = 0;
         upperWr = 0;
      end
      else
      begin
         junk <= ~junk;
         csPrev <= !memCs_n;
         gCnt <= mem_request_n ? 8'h00 : ((gCnt == 8'hFF) ? gCnt : gCnt + 8'h01);
         wCnt <= strobe ? wCnt + 4'h1 : 4'h0;
         if (strobe)
         begin
            strobes++;
            lastType <= access_type_code;
         end
         if (!memCs_n && !memWr_n)
         begin
            mem[{buffer_half_sel, memAddr[9:0]}] <= memDout;
            if (buffer_half_sel)
               upperWr++;
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the backend mapper and memory sequencer
// assumes the memory model stands on the backend pins
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import rtbm_pkg::*;
;
   logic        core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0]  avs_address = 4'h0, waitCyc = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic        avs_waitrequest, accValid = 1'b0, accTx = 1'b0, accModeData = 1'b0;
   logic        accModeInternal = 1'b0, accReady, accDone, memIfErr, cmdForUs, cmdBroadcast;
   logic [1:0]  accKind = 2'h0, access_type_code;
   logic [4:0]  accSubaddr = 5'h00, accWordIdx = 5'h00, cmdRtAddr = 5'h00;
   logic [15:0] accWrData = 16'h0, accRdData, memDout, memDin, rdv;
   logic        cmdStrobe = 1'b0, msgEnd = 1'b0, msgError = 1'b0, msgIrq, test_overrun_tx;
   logic        illegal_state_pulse, mem_request_n, memGrant_n, memWr_n, memRd_n, memCs_n;
   logic        memWait_n, memCen, memDen, buffer_half_sel, errSeen = 1'b0;
   logic [10:0] memAddr;
   logic [7:0]  grantDly = 8'h00;
   int          badCount = 0, checksDone = 0, reqRun = 0, maxReq = 0, illegals = 0, s0;

   rtbm_backend u_rtbm_backend (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .accValid,
      .accKind, .accTx, .accSubaddr, .accWordIdx, .accModeData, .accModeInternal, .accWrData,
      .accReady, .accDone, .accRdData, .memIfErr, .cmdStrobe, .cmdRtAddr, .cmdForUs,
      .cmdBroadcast, .msgEnd, .msgError, .msgIrq, .test_overrun_tx, .illegal_state_pulse,
      .mem_request_n, .memGrant_n, .memWr_n, .memRd_n, .memCs_n, .memWait_n, .access_type_code,
      .memAddr, .memDout, .memDin, .memCen, .memDen, .buffer_half_sel);
   rtbm_mem_model u_rtbm_mem_model (.core_clk, .rst, .mem_request_n, .memWr_n, .memRd_n,
      .memCs_n, .memAddr, .memDout, .buffer_half_sel, .access_type_code, .grantDly, .waitCyc,
      .memGrant_n, .memWait_n, .memDin);

   // ==========================================
   // clock, monitors, shared tasks
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      reqRun = (mem_request_n === 1'b0) ? reqRun + 1 : 0;
      maxReq = (reqRun > maxReq) ? reqRun : maxReq;
      if (memIfErr === 1'b1)
         errSeen = 1'b1;
      if (illegal_state_pulse === 1'b1)
         illegals++;
   end
   task automatic chk(input logic ok, input string m);
      checksDone++;
      if (ok !== 1'b1)
      begin
         badCount++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", badCount, checksDone);
      if (badCount == 0 && checksDone > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk(n < 50, "register bus hang");
   endtask
   task automatic acc(input logic [1:0] k, input logic tx, input logic [4:0] sa, idx,
                      input logic md, mi, input logic [15:0] wd);
      int n;
      @(posedge core_clk);
      accValid <= 1'b1;
      accKind <= k;
      accTx <= tx;
      accSubaddr <= sa;
      accWordIdx <= idx;
      accModeData <= md;
      accModeInternal <= mi;
      accWrData <= wd;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (accReady !== 1'b1 && n < 300);
      accValid <= 1'b0;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (accDone !== 1'b1 && n < 300);
      rdv = accRdData;
      chk(n < 300, "access never done");
   endtask
   task automatic ev(input logic [4:0] a, input logic f, b);
      @(posedge core_clk);
      cmdStrobe <= 1'b1;
      cmdRtAddr <= a;
      @(posedge core_clk);
      cmdStrobe <= 1'b0;
      @(posedge core_clk);
      chk(cmdForUs === f && cmdBroadcast === b, "command decode");
   endtask
   task automatic irq(input logic e, x);
      @(posedge core_clk);
      msgEnd <= 1'b1;
      msgError <= e;
      @(posedge core_clk);
      msgEnd <= 1'b0;
      @(posedge core_clk);
      chk(msgIrq === x, "message interrupt");
   endtask

   // ==========================================
   // scenarios
   task automatic t_map();
      av(1'b0, RegCfgOfs, 32'h0);
      chk(q === 32'h0000_0003, "config reset");
      av(1'b0, 4'hC, 32'h0);
      chk(q === 32'h0, "unmapped read");
      acc(2'h0, 1'b0, 5'h01, 5'h00, 1'b0, 1'b0, 16'hA5A1);
      chk(u_rtbm_mem_model.mem[11'h020] === 16'hA5A1, "rx word");
      chk(u_rtbm_mem_model.lastType === 2'h0, "data type");
      acc(2'h0, 1'b0, 5'h1E, 5'h1F, 1'b0, 1'b0, 16'h0F3C);
      chk(u_rtbm_mem_model.mem[11'h3DF] === 16'h0F3C, "rx sa30 end");
      u_rtbm_mem_model.mem[11'h43F] = 16'h1234;
      acc(2'h0, 1'b1, 5'h01, 5'h1F, 1'b0, 1'b0, 16'h0);
      chk(rdv === 16'h1234, "tx read");
   endtask
   task automatic t_status();
      acc(2'h1, 1'b1, 5'h18, 5'h00, 1'b0, 1'b0, 16'h8001);
      chk(u_rtbm_mem_model.mem[11'h3F8] === 16'h8001, "tx status");
      chk(u_rtbm_mem_model.lastType === 2'h1, "status type");
      acc(2'h2, 1'b0, 5'h05, 5'h00, 1'b0, 1'b0, 16'h2C45);
      chk(u_rtbm_mem_model.mem[11'h005] === 16'h2C45, "rx command");
      chk(u_rtbm_mem_model.lastType === 2'h2, "command type");
      av(1'b1, RegCfgOfs, 32'h0);
      s0 = u_rtbm_mem_model.strobes;
      acc(2'h1, 1'b0, 5'h06, 5'h00, 1'b0, 1'b0, 16'h1);
      acc(2'h2, 1'b0, 5'h06, 5'h00, 1'b0, 1'b0, 16'h1);
      chk(u_rtbm_mem_model.strobes == s0, "suppressed writes");
   endtask
   task automatic t_loop_mode();
      av(1'b1, RegCfgOfs, 32'h83);
      u_rtbm_mem_model.mem[11'h3C3] = 16'h5A5A;
      u_rtbm_mem_model.mem[11'h7C3] = 16'hFFFF;
      acc(2'h0, 1'b1, 5'h1E, 5'h03, 1'b0, 1'b0, 16'h0);
      chk(rdv === 16'h5A5A, "looped read");
      acc(2'h1, 1'b1, 5'h1E, 5'h00, 1'b0, 1'b0, 16'h4321);
      chk(u_rtbm_mem_model.mem[11'h3FE] === 16'h4321, "looped status");
      av(1'b1, RegCfgOfs, 32'h03);
      acc(2'h0, 1'b1, 5'h1E, 5'h03, 1'b0, 1'b0, 16'h0);
      chk(rdv === 16'hFFFF, "separate buffers");
      av(1'b1, RegVectorOfs, 32'hBEEF);
      s0 = u_rtbm_mem_model.strobes;
      acc(2'h0, 1'b1, 5'h02, 5'h01, 1'b1, 1'b0, 16'h0);
      chk(rdv === 16'hBEEF && u_rtbm_mem_model.strobes == s0, "vector word");
      av(1'b1, RegCfgOfs, 32'h07);
      u_rtbm_mem_model.mem[11'h441] = 16'h1111;
      acc(2'h0, 1'b1, 5'h02, 5'h01, 1'b1, 1'b0, 16'h0);
      chk(rdv === 16'h1111, "mode data in memory");
      s0 = u_rtbm_mem_model.strobes;
      acc(2'h0, 1'b1, 5'h02, 5'h01, 1'b1, 1'b1, 16'h0);
      chk(rdv === 16'hBEEF && u_rtbm_mem_model.strobes == s0, "internal word");
   endtask
   task automatic t_events();
      av(1'b1, RegCfgOfs, 32'h0543);
      ev(5'h1F, 1'b1, 1'b1);
      ev(5'h05, 1'b1, 1'b0);
      ev(5'h07, 1'b0, 1'b0);
      av(1'b1, RegCfgOfs, 32'h1F03);
      ev(5'h1F, 1'b1, 1'b0);
      irq(1'b1, 1'b0);
      irq(1'b0, 1'b1);
      av(1'b1, RegCfgOfs, 32'h0B);
      irq(1'b1, 1'b1);
      av(1'b1, RegCfgOfs, 32'h23);
      repeat (2) @(posedge core_clk);
      chk(test_overrun_tx === 1'b1, "overrun test on");
      av(1'b1, RegCfgOfs, 32'h03);
      repeat (2) @(posedge core_clk);
      chk(test_overrun_tx === 1'b0, "overrun test off");
   endtask
   task automatic t_async_timeout();
      av(1'b1, RegCfgOfs, 32'h13);
      waitCyc <= 4'h3;
      grantDly <= 8'h04;
      u_rtbm_mem_model.mem[11'h421] = 16'h7777;
      acc(2'h0, 1'b1, 5'h01, 5'h01, 1'b0, 1'b0, 16'h0);
      chk(rdv === 16'h7777, "async read");
      acc(2'h0, 1'b0, 5'h02, 5'h02, 1'b0, 1'b0, 16'h6E6E);
      chk(u_rtbm_mem_model.mem[11'h042] === 16'h6E6E, "async write");
      grantDly <= 8'hC8;
      acc(2'h0, 1'b0, 5'h02, 5'h03, 1'b0, 1'b0, 16'h1);
      chk(errSeen === 1'b1 && maxReq <= AccLimitCyc, "access time limit");
      grantDly <= 8'h00;
      waitCyc <= 4'h0;
      chk(u_rtbm_mem_model.upperWr == 0 && illegals == 0, "upper writes or bad state");
   endtask

   initial
   begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      t_map();
      t_status();
      t_loop_mode();
      t_events();
      t_async_timeout();
      conclude();
   end
   initial
   begin
      #200000;
      badCount++;
      conclude();
   end
endmodule
`default_nettype wire
